// [design/bridge_reset_power_state.sv]
// reset and power-state sequencer of a pci-to-pci bridge
// Operation
// R01: d3hot stops secondary clocks when pin allows
// R02: writes requesting d1 or d2 are ignored
// R03: d3hot to d0 does chip reset, no bus reset
// R04: d3cold return is a full power-up reset
// R05: primary reset tristates all, resets registers; secondary ad/cbe/par are driven low instead
// R06: primary reset synchronised into the clock domain
// R07: primary release shifts mask, then 100 us
// R08: bridge control bit 6 drives secondary reset
// R09: chip reset bit also sets bit 6
// R10: chip reset releases after 100 us if clear
// R11: hold reset until bit cleared and mask in
// R12: reset tristates controls, drives data lines low
// R13: secondary reset flushes all transaction buffers
// R14: config access stays alive during bit reset
// R15: chip reset resets state and sets bit 6
// R16: chip reset bit self-clears within 20 clocks
// R17: no response to accesses during chip reset
// R18: power events are not forwarded
// R19: delay counter runs on primary clock
`timescale 1ns/1ps
`default_nettype none
module bridge_reset_power_state
  import rst_pwr_pkg::*;
#(
  parameter int unsigned DELAY_CYC = SEC_RST_DELAY_CYC
) (
  input  wire logic        clk,                // primary clock
  input  wire logic        nrst,               // power-up reset, active low
  input  wire logic        pri_rst_n,          // primary reset pin, async
  input  wire logic        clock_stop_enable_pin, // lets d3hot stop clocks
  input  wire logic        mask_done,          // clock mask shift complete
  input  wire logic        cfg_wr,             // config write strobe
  input  wire logic        cfg_rd,             // config read strobe
  input  wire logic [7:0]  cfg_addr,           // config byte offset
  input  wire logic [15:0] cfg_wdata,          // config write data
  input  wire logic [1:0]  cfg_be,             // config byte enables
  output logic             cfg_ack,            // access answered
  output logic [15:0]      cfg_rdata,          // config read data
  output logic             mask_start,         // starts clock mask shift
  output logic             sec_rst_n,          // secondary bus reset
  output logic             sec_clk_en,         // secondary clocks run
  output logic             pri_sig_oe_n,       // primary drivers off, low=on
  output logic             sec_ctl_oe_n,       // secondary controls + grants
  output logic             sec_ad_force_low,   // ad/cbe/par driven low
  output logic             sec_cmd_byte_en_n_oe_n, // cbe drive enable
  output logic             buf_flush,          // flush posted/delayed bufs
  output logic             chip_rst_busy,      // internal chip reset
  output logic             power_event_n_oe_n  // never driven
);
  // elaboration-time refusal of a delay the counter cannot hold
  if (DELAY_CYC < 1) begin : g_bad_delay
    $error("DELAY_CYC must be at least one");
  end

  logic        prst_s1_r, prst_s2_r;
  logic [15:0] bctl_r, bctl_nxt;
  logic [7:0]  diag_r, diag_nxt;
  logic [1:0]  pstate_r, pstate_nxt;
  logic [4:0]  chip_cnt_r;
  logic        chip_act_r;
  logic [$clog2(DELAY_CYC+1)-1:0] dly_r;
  sec_rst_state_t st_r, st_nxt;
  logic        sec_rst_n_r, mask_start_r, ack_r;
  logic [15:0] rdata_r;

  // two-flop sync of the asynchronous primary reset pin
  always_ff @(posedge clk) begin // see R06
    if (!nrst) begin
      prst_s1_r <= 1'b0;
      prst_s2_r <= 1'b0;
    end else begin
      prst_s1_r <= pri_rst_n;
      prst_s2_r <= prst_s1_r;
    end
  end

  wire pri_rst   = !prst_s2_r;
  wire sel_bctl  = cfg_addr == BRIDGE_CTRL_OFS;
  wire sel_diag  = cfg_addr == DIAG_CTRL_OFS;
  wire sel_pm    = cfg_addr == PM_CSR_OFS;
  // chip reset blocks every access, bit reset does not
  wire acc_ok    = !chip_act_r && !pri_rst; // see R14 see R17
  wire wr_ok     = cfg_wr && acc_ok;
  wire wr_bctl   = wr_ok && sel_bctl && cfg_be[1];
  wire wr_diag   = wr_ok && sel_diag && cfg_be[0];
  wire chip_go   = wr_diag && cfg_wdata[CHIP_RST_BIT];
  wire wr_pm     = wr_ok && sel_pm && cfg_be[0];
  wire ps_req_ok = cfg_wdata[1:0] == PS_D0 || cfg_wdata[1:0] == PS_D3HOT;
  wire wake      = wr_pm && pstate_r == PS_D3HOT &&
                   cfg_wdata[1:0] == PS_D0;
  wire chip_trig = chip_go || wake;
  wire bus_bit   = bctl_r[SEC_BUS_RST_BIT];

  always_comb begin
    bctl_nxt = bctl_r;
    if (wr_bctl) begin
      bctl_nxt[15:8] = cfg_wdata[15:8];
    end
    if (sel_bctl && wr_ok && cfg_be[0]) begin
      bctl_nxt[7:0] = cfg_wdata[7:0]; // see R08
    end
    if (chip_go) begin
      bctl_nxt = BRIDGE_CTRL_RST;
      bctl_nxt[SEC_BUS_RST_BIT] = 1'b1; // see R09 see R15
    end else if (wake) begin
      bctl_nxt = BRIDGE_CTRL_RST; // see R03
    end
  end

  always_comb begin
    diag_nxt = diag_r;
    if (chip_trig) begin
      diag_nxt = DIAG_CTRL_RST;
      diag_nxt[CHIP_RST_BIT] = chip_go;
    end else if (wr_diag) begin
      diag_nxt[7:1] = cfg_wdata[7:1];
    end
    if (chip_act_r && chip_cnt_r == 5'(CHIP_RST_CYC)) begin
      diag_nxt[CHIP_RST_BIT] = 1'b0; // see R16
    end
  end

  always_comb begin
    pstate_nxt = pstate_r;
    if (wake) begin
      pstate_nxt = PS_D0;
    end else if (wr_pm && ps_req_ok) begin
      pstate_nxt = cfg_wdata[1:0]; // see R02
    end
  end

  // power-up and primary reset share one path: a full initialisation
  wire hard_rst = !nrst || pri_rst; // see R04 see R05

  always_ff @(posedge clk) begin
    if (hard_rst) begin
      bctl_r   <= BRIDGE_CTRL_RST;
      diag_r   <= DIAG_CTRL_RST;
      pstate_r <= PS_D0;
    end else begin
      bctl_r   <= bctl_nxt;
      diag_r   <= diag_nxt;
      pstate_r <= pstate_nxt;
    end
  end

  // internal chip reset window, well inside 20 clocks of the write
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      chip_act_r <= 1'b0;
      chip_cnt_r <= 5'h00;
    end else if (chip_trig) begin
      chip_act_r <= 1'b1;
      chip_cnt_r <= 5'h00;
    end else if (chip_act_r) begin
      chip_cnt_r <= chip_cnt_r + 5'h01;
      if (chip_cnt_r == 5'(CHIP_RST_CYC)) begin
        chip_act_r <= 1'b0; // see R16
      end
    end
  end

  // secondary reset sequencer; wake from d3hot skips it entirely
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SR_POR:   if (!pri_rst) st_nxt = SR_MASK; // see R07
      SR_MASK:  if (mask_done) st_nxt = SR_HOLD;
      SR_HOLD:  if (!bus_bit && !chip_act_r) st_nxt = SR_DELAY; // see R11
      SR_DELAY: begin
        if (bus_bit || chip_go) begin
          st_nxt = SR_HOLD;
        end else if (dly_r == '0) begin
          st_nxt = SR_HOLD;
        end
      end
      default:  st_nxt = SR_POR;
    endcase
    if (pri_rst) st_nxt = SR_POR;
  end

  wire rel_now = st_r == SR_DELAY && dly_r == '0 && !bus_bit && !chip_go;
  // next reset level: bus parking follows it on the same edge
  wire sec_rst_set   = pri_rst || bus_bit || chip_go; // see R07 see R08 see R09
  wire sec_rst_n_nxt = sec_rst_set ? 1'b0 :
                       rel_now     ? 1'b1 : sec_rst_n_r; // see R10

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r        <= SR_POR;
      sec_rst_n_r <= 1'b0;
      dly_r       <= '0;
    end else begin
      st_r <= st_nxt;
      sec_rst_n_r <= sec_rst_n_nxt;
      if (st_nxt == SR_DELAY && st_r != SR_DELAY) begin
        // 100 us at the primary clock rate
        dly_r <= ($clog2(DELAY_CYC+1))'(DELAY_CYC - 1); // see R19
      end else if (dly_r != '0) begin
        dly_r <= dly_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_start_r <= 1'b0;
    end else begin
      mask_start_r <= st_r == SR_POR && !pri_rst;
    end
  end

  wire [15:0] rd_mux = sel_bctl ? bctl_r :
                       sel_diag ? {8'h00, diag_r} :
                       sel_pm   ? {14'h0000, pstate_r} : 16'h0000;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_r   <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ack_r   <= (cfg_wr || cfg_rd) && acc_ok; // see R17
      rdata_r <= (cfg_rd && acc_ok) ? rd_mux : 16'h0000;
    end
  end

  // taken from the next level so control drivers let go with the reset edge
  wire sec_in_rst = !sec_rst_n_nxt;
  // clocks stop during primary reset, and in d3hot only if the strap pin allows it
  wire clk_stop   = pstate_r == PS_D3HOT && clock_stop_enable_pin;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sec_clk_en             <= 1'b0;
      pri_sig_oe_n           <= 1'b1;
      sec_ctl_oe_n           <= 1'b1;
      sec_ad_force_low       <= 1'b1;
      sec_cmd_byte_en_n_oe_n <= 1'b0;
      buf_flush              <= 1'b1;
      chip_rst_busy          <= 1'b0;
      power_event_n_oe_n     <= 1'b1;
    end else begin
      sec_clk_en             <= !pri_rst && !clk_stop; // see R01 see R03
      pri_sig_oe_n           <= pri_rst || chip_act_r; // see R05 see R15
      sec_ctl_oe_n           <= pri_rst || chip_act_r || sec_in_rst; // see R12
      sec_ad_force_low       <= sec_in_rst; // see R12
      sec_cmd_byte_en_n_oe_n <= !sec_in_rst && (pri_rst || chip_act_r);
      buf_flush              <= sec_in_rst || chip_act_r; // see R13
      chip_rst_busy          <= chip_act_r;
      power_event_n_oe_n     <= 1'b1; // see R18
    end
  end

  assign cfg_ack    = ack_r;
  assign cfg_rdata  = rdata_r;
  assign mask_start = mask_start_r;
  assign sec_rst_n  = sec_rst_n_r;
endmodule
`default_nettype wire

// [include/rst_pwr_pkg.sv]
// constants for the bridge reset and power-state sequencer
package rst_pwr_pkg;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned SEC_RST_DELAY_US = 100;
  localparam int unsigned SEC_RST_DELAY_CYC = SEC_RST_DELAY_US * CLK_MHZ;
  localparam int unsigned CHIP_RST_CLKS    = 20;
  localparam int unsigned CHIP_RST_CYC     = CHIP_RST_CLKS - 4;
  localparam logic [7:0] BRIDGE_CTRL_OFS   = 8'h3E;
  localparam logic [7:0] DIAG_CTRL_OFS     = 8'h41;
  localparam logic [7:0] PM_CSR_OFS        = 8'hE0;
  localparam int unsigned SEC_BUS_RST_BIT  = 6;
  localparam int unsigned CHIP_RST_BIT     = 0;
  localparam logic [15:0] BRIDGE_CTRL_RST  = 16'h0000;
  localparam logic [7:0] DIAG_CTRL_RST     = 8'h00;
  localparam logic [1:0] PS_D0             = 2'h0;
  localparam logic [1:0] PS_D1             = 2'h1;
  localparam logic [1:0] PS_D2             = 2'h2;
  localparam logic [1:0] PS_D3HOT          = 2'h3;
  typedef enum logic [3:0] {
    SR_POR   = 4'b0001,
    SR_MASK  = 4'b0010,
    SR_HOLD  = 4'b0100,
    SR_DELAY = 4'b1000
  } sec_rst_state_t;
endpackage

// [verification/rst_seq_asserts.sv]
// property checks for the reset and power-state sequencer
`timescale 1ns/1ps
`default_nettype none
module rst_seq_asserts #(parameter int unsigned DELAY_CYC = 20) (
  input wire logic clk, nrst, pri_rst_n, mask_done, cfg_wr, cfg_rd,
  input wire logic cfg_ack, sec_rst_n, pri_sig_oe_n, sec_ctl_oe_n,
  input wire logic sec_ad_force_low, buf_flush, chip_rst_busy,
  input wire logic power_event_n_oe_n);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_busy_on; $rose(chip_rst_busy); endsequence
  sequence s_pri_low; !pri_rst_n [*4]; endsequence
  property p_evt; power_event_n_oe_n; endproperty
  property p_drv; !sec_rst_n |-> sec_ad_force_low && sec_ctl_oe_n;
  endproperty
  property p_flush; !sec_rst_n |-> buf_flush; endproperty
  property p_ack; cfg_ack |-> $past(cfg_wr) || $past(cfg_rd); endproperty
  property p_quiet; chip_rst_busy && $past(chip_rst_busy) |-> !cfg_ack;
  endproperty
  property p_clr; s_busy_on |-> ##[1:19] !chip_rst_busy; endproperty
  property p_pri; s_pri_low |-> pri_sig_oe_n && !sec_rst_n; endproperty
  // release only after the mask is in and the full delay has run
  property p_rel; $rose(sec_rst_n) |->
    mask_done && pri_rst_n && !$past(sec_rst_n, DELAY_CYC); endproperty
  a_evt: assert property (p_evt) else $error("event driven");
  a_drv: assert property (p_drv) else $error("bus not parked");
  a_flush: assert property (p_flush) else $error("no flush");
  a_ack: assert property (p_ack) else $error("stray ack");
  a_quiet: assert property (p_quiet) else $error("ack in reset");
  a_clr: assert property (p_clr) else $error("chip reset long");
  a_pri: assert property (p_pri) else $error("pri reset");
  a_rel: assert property (p_rel) else $error("early release");
endmodule
bind bridge_reset_power_state rst_seq_asserts #(.DELAY_CYC(DELAY_CYC))
  i_rst_seq_asserts (.clk, .nrst, .pri_rst_n, .mask_done, .cfg_wr,
  .cfg_rd, .cfg_ack, .sec_rst_n, .pri_sig_oe_n, .sec_ctl_oe_n,
  .sec_ad_force_low, .buf_flush, .chip_rst_busy, .power_event_n_oe_n);
`default_nettype wire

// [verification/mask_shift_model.sv]
// clock mask shift logic standing beside the block
`timescale 1ns/1ps
`default_nettype none
module mask_shift_model #(parameter int LAT = 16) (
  input wire logic clk, pri_rst_n, mask_start,
  output logic mask_done = 1'b0);
  int cnt = 0;
  logic run = 1'b0;
  always @(posedge clk) begin
    if (!pri_rst_n) begin
      cnt <= 0;
      run <= 1'b0;
      mask_done <= 1'b0;
    end else if (mask_start) begin
      run <= 1'b1;
    end else if (run && !mask_done) begin
      cnt <= cnt + 1;
      if (cnt == LAT) mask_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [verification/bridge_reset_power_state_tb.sv]
// self-checking bench for the reset and power-state sequencer
`timescale 1ns/1ps
`default_nettype none
module bridge_reset_power_state_tb;
  import rst_pwr_pkg::*;
  localparam int D = 20;
  logic clk = 0, nrst = 0, pri_rst_n = 0, pin = 0, cfg_wr = 0, cfg_rd = 0;
  logic [7:0] cfg_addr = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000, q, cfg_rdata;
  logic [1:0] cfg_be = 2'h3;
  logic mask_start, mask_done, cfg_ack, sec_rst_n, sec_clk_en, pev, ok;
  logic pri_sig_oe_n, sec_ctl_oe_n, force_lo, cbe_oe_n, flush, busy;
  int miscompares = 0, n_checks = 0, cyc = 0, n, seed = 32'hc924a9be;
  int bctl;
  bridge_reset_power_state #(.DELAY_CYC(D)) i_bridge_reset_power_state (
    .clk, .nrst, .pri_rst_n, .clock_stop_enable_pin(pin), .mask_done,
    .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_ack, .cfg_rdata,
    .mask_start, .sec_rst_n, .sec_clk_en, .pri_sig_oe_n, .sec_ctl_oe_n,
    .sec_ad_force_low(force_lo), .sec_cmd_byte_en_n_oe_n(cbe_oe_n),
    .buf_flush(flush), .chip_rst_busy(busy), .power_event_n_oe_n(pev));
  mask_shift_model #(.LAT(16)) i_mask_shift_model (.clk, .pri_rst_n,
    .mask_start, .mask_done);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one strobe cycle, then look for the answer over three cycles
  task cfg(input bit w, input logic [7:0] a, input logic [15:0] d);
    ok = 0;
    @(negedge clk);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = a;
    cfg_wdata = d;
    for (int i = 0; i < 3 && !ok; i++) begin
      @(negedge clk);
      if (i == 0) {cfg_wr, cfg_rd} = 2'b00;
      if (cfg_ack === 1'b1) begin
        ok = 1;
        q = cfg_rdata;
      end
    end
  endtask
  task wait_rel;
    n = 0;
    while (sec_rst_n !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1;
    pri_rst_n = 1;
    wait_rel();
    chk("pwrup", 16'(n > D && n < 200), 16'h0001);
    chk("idle", {pri_sig_oe_n, sec_ctl_oe_n, force_lo, flush, pev}, 5'h01);
    bctl = 0;
    cfg(0, 8'h3E, 0);
    chk("bctl", q, 16'(bctl));
    cfg(0, 8'h41, 0);
    chk("diag", q, 16'h0000);
    $display("test reset done");
    bctl = 16'h0040;
    cfg(1, 8'h3E, 16'(bctl));
    @(negedge clk);
    chk("srst", {sec_rst_n, force_lo, flush, sec_ctl_oe_n, cbe_oe_n}, 5'h0E);
    cfg(0, 8'h3E, 0);
    chk("alive", {ok, q}, {1'b1, 16'(bctl)});
    bctl = 0;
    cfg(1, 8'h3E, 16'(bctl));
    wait_rel();
    chk("rel", 16'(n >= D - 3 && n <= D + 3), 16'h0001);
    $display("test bus reset done");
    cfg(1, 8'h41, 16'h0001);
    @(negedge clk);
    chk("busy", busy, 1'b1);
    cfg(0, 8'h3E, 0);
    chk("refused", ok, 1'b0);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("selfclr", 16'(n <= 18), 16'h0001);
    bctl = 16'h0040;
    cfg(0, 8'h3E, 0);
    chk("bit6", q, 16'(bctl));
    cfg(0, 8'h41, 0);
    chk("diag", q, 16'h0000);
    repeat (D + 8) @(negedge clk);
    chk("held", sec_rst_n, 1'b0);
    bctl = 0;
    cfg(1, 8'h3E, 16'(bctl));
    wait_rel();
    chk("rel", 16'(n >= D - 3 && n <= D + 3), 16'h0001);
    $display("test chip reset done");
    cfg(1, PM_CSR_OFS, 16'(1 + ($unsigned($random(seed)) % 2)));
    cfg(0, PM_CSR_OFS, 0);
    chk("ps", q & 16'h0003, 16'(PS_D0));
    pin = $random(seed);
    cfg(1, PM_CSR_OFS, 16'(PS_D3HOT));
    @(negedge clk);
    chk("clkstop", sec_clk_en, !pin);
    cfg(1, PM_CSR_OFS, 16'(PS_D0));
    n = 0;
    repeat (24) begin
      @(negedge clk);
      if (sec_rst_n !== 1'b1) n++;
    end
    chk("wake", 16'(n), 16'h0000);
    chk("wake_clk", sec_clk_en, 1'b1);
    $display("test power done");
    pri_rst_n = 0;
    repeat (4) @(negedge clk);
    chk("pri", {pri_sig_oe_n, sec_ctl_oe_n, sec_rst_n}, 3'b110);
    cfg(0, 8'h3E, 0);
    chk("pri_acc", ok, 1'b0);
    pri_rst_n = 1;
    wait_rel();
    chk("pri_rel", 16'(n > D && n < 200), 16'h0001);
    $display("test primary reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
